// ===== rtl/flash_pins_defines.svh
// Purpose: Timing counts and field widths of the flash pin controller
// Assumes: mclk at 100 MHz
// Notes:   Reset and ready counts derive from times in ns; strobe count is given in cycles
`ifndef FLASH_PINS_DEFINES_SVH
`define FLASH_PINS_DEFINES_SVH

`define CLK_PERIOD_NS             10
`define RESET_LOW_MIN_TIME_NS     500
`define RESET_RELEASE_TO_ACCESS_NS 50
`define READY_RELEASE_TO_ACCESS_NS 0
`define GLITCH_MIN_NS             5
`define RESET_LOW_CYC   ((`RESET_LOW_MIN_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RESET_REL_CYC   ((`RESET_RELEASE_TO_ACCESS_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define READY_REL_CYC   ((`READY_RELEASE_TO_ACCESS_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define STROBE_CYC_DEF  4
`define READY_WAIT_MAX  16'h0fff
`define ADDR_W          20
`define DATA_W          16
`define CMD_W           8

`endif

// ===== rtl/flash_pins_pkg.sv
// Purpose: Types for the flash pin controller
// Assumes: Widths from flash_pins_defines.svh
// Notes:   Requests and pin drives travel as structs
`default_nettype none
`include "flash_pins_defines.svh"
package flash_pins_pkg;
   typedef enum logic [2:0] {
      ST_RESET_LOW  = 3'b000,
      ST_RESET_WAIT = 3'b001,
      ST_IDLE       = 3'b011,
      ST_SETUP      = 3'b010,
      ST_STROBE     = 3'b110,
      ST_HOLD       = 3'b111
   } host_state_t;

   typedef struct packed {
      logic                 write;
      logic                 id_mode;
      logic                 unprotect;
      logic [`ADDR_W-1:0]   addr;
      logic [`DATA_W-1:0]   wdata;
   } bus_req_t;

   typedef struct packed {
      logic [`ADDR_W-1:0]   addr_lines;
      logic                 top_out;
      logic                 top_oe;
      logic [`DATA_W-2:0]   data_out;
      logic                 data_oe;
      logic                 chip_act_n;
      logic                 out_drv_n;
      logic                 wr_strobe_n;
      logic                 reset_unprotect_n;
      logic                 elevated_id_level;
      logic                 addr_elevated;
      logic                 word_mode;
   } pin_drive_t;
endpackage : flash_pins_pkg
`default_nettype wire

// ===== rtl/flash_pin_sync.sv
// Purpose: Two-flop synchroniser for pin inputs
// Assumes: Inputs asynchronous to mclk
// Notes:   First stage read only by second stage
`default_nettype none
module flash_pin_sync #(
   parameter int W = 1
) (
   input  wire logic         mclk,
   input  wire logic         nrst,
   input  wire logic         ce,
   input  wire logic [W-1:0] async_in,
   output logic      [W-1:0] sync_out
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
   } sync_state_t;
   sync_state_t st_reg;
   sync_state_t st_next;

   initial begin
      if (W < 1) $error("W must be positive");
   end

   always_comb begin
      st_next    = st_reg;
      st_next.s1 = async_in;
      st_next.s2 = st_reg.s1;
   end

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         st_reg <= '0;
      end else if (ce) begin
         st_reg <= st_next;
      end
   end

   assign sync_out = st_reg.s2;
endmodule : flash_pin_sync
`default_nettype wire

// ===== rtl/flash_pin_host.sv
// Purpose: Host-side controller driving a parallel flash over its pins
// Assumes: Strobe lengths in mclk cycles exceed the device's minimum timings
// Notes:   One request at a time; reads capture data before releasing strobes
// Notes on behaviour
// - Hold reset low, then wait recovery times
// - No cycle until ready/busy is released
// - Read: address, activation and drive low
// - Output drive high through every write
`default_nettype none
`include "flash_pins_defines.svh"
module flash_pin_host #(
   parameter int STROBE_CYC = `STROBE_CYC_DEF,
   parameter int SETUP_CYC  = 1
) (
   input  wire logic                   mclk,
   input  wire logic                   nrst,
   input  wire logic                   ce,
   input  wire logic                   word_mode,
   input  wire logic                   req_valid,
   input  wire flash_pins_pkg::bus_req_t req,
   input  wire logic                   reset_req,
   input  wire logic [`DATA_W-2:0]     data_in,
   input  wire logic                   top_in,
   input  wire logic                   ready_busy_od,
   output logic                        req_ready,
   output logic                        rsp_valid,
   output logic [`DATA_W-1:0]          rsp_data,
   output logic                        ready_seen,
   output flash_pins_pkg::pin_drive_t  pins
);
   localparam int CNT_W = 16;
   localparam int RL_CYC = (`RESET_LOW_CYC < 1) ? 1 : `RESET_LOW_CYC;
   localparam int RW_CYC = (`RESET_REL_CYC > `READY_REL_CYC) ? `RESET_REL_CYC : `READY_REL_CYC;

   initial begin
      if (STROBE_CYC * `CLK_PERIOD_NS <= `GLITCH_MIN_NS || STROBE_CYC > 255) $error("STROBE_CYC out of range");
      if (SETUP_CYC < 1 || SETUP_CYC > 255) $error("SETUP_CYC out of range");
   end

   typedef struct packed {
      flash_pins_pkg::host_state_t state;
      logic [CNT_W-1:0]            cnt;
      flash_pins_pkg::bus_req_t    cur;
      flash_pins_pkg::pin_drive_t  pins;
      logic                        req_ready;
      logic                        rsp_valid;
      logic [`DATA_W-1:0]          rsp_data;
      logic                        ready_seen;
   } host_t;

   host_t st_reg;
   host_t st_next;
   logic [`DATA_W:0] in_sync;
   logic             rb_released;

   flash_pin_sync #(.W(`DATA_W + 1)) u_sync (
      .mclk    (mclk),
      .nrst    (nrst),
      .ce      (ce),
      .async_in({ready_busy_od, top_in, data_in}),
      .sync_out(in_sync)
   );

   // Open-drain line reads high once the device lets go
   assign rb_released = in_sync[`DATA_W];

   always_comb begin
      st_next           = st_reg;
      st_next.rsp_valid = 1'b0;
      st_next.pins.word_mode = word_mode;
      unique case (st_reg.state)
         flash_pins_pkg::ST_RESET_LOW: begin
            st_next.pins.reset_unprotect_n = 1'b0;
            st_next.pins.chip_act_n        = 1'b1;
            st_next.req_ready              = 1'b0;
            if (st_reg.cnt >= CNT_W'(RL_CYC - 1)) begin
               st_next.state                  = flash_pins_pkg::ST_RESET_WAIT;
               st_next.pins.reset_unprotect_n = 1'b1;
               st_next.cnt                    = '0;
            end else begin
               st_next.cnt = st_reg.cnt + 1'b1;
            end
         end
         flash_pins_pkg::ST_RESET_WAIT: begin
            // Both recovery times and ready release must pass
            if (st_reg.cnt < CNT_W'(RW_CYC)) begin
               st_next.cnt = st_reg.cnt + 1'b1;
            end
            if (rb_released && st_reg.cnt >= CNT_W'(RW_CYC)) begin
               st_next.state      = flash_pins_pkg::ST_IDLE;
               st_next.req_ready  = 1'b1;
               st_next.ready_seen = 1'b1;
            end
         end
         flash_pins_pkg::ST_IDLE: begin
            st_next.ready_seen = rb_released;
            if (reset_req) begin
               st_next.state     = flash_pins_pkg::ST_RESET_LOW;
               st_next.req_ready = 1'b0;
               st_next.cnt       = '0;
               // Pin goes low now so the counted pulse is full length
               st_next.pins.reset_unprotect_n = 1'b0;
               st_next.pins.chip_act_n        = 1'b1;
            end else if (req_valid && rb_released) begin
               st_next.cur                    = req;
               st_next.req_ready              = 1'b0;
               st_next.state                  = flash_pins_pkg::ST_SETUP;
               st_next.cnt                    = '0;
               // Address first, activation follows after setup
               st_next.pins.addr_lines        = req.addr;
               st_next.pins.elevated_id_level = req.unprotect;
               st_next.pins.addr_elevated     = req.id_mode;
               st_next.pins.top_oe            = ~word_mode;
               st_next.pins.top_out           = word_mode ? req.wdata[`DATA_W-1] : req.addr[0];
               st_next.pins.data_out          = req.wdata[`DATA_W-2:0];
               st_next.pins.out_drv_n         = 1'b1;
               st_next.pins.wr_strobe_n       = 1'b1;
               st_next.pins.chip_act_n        = 1'b1;
               st_next.pins.data_oe           = 1'b0;
               if (!word_mode) begin
                  st_next.pins.addr_lines = {1'b0, req.addr[`ADDR_W-1:1]};
               end
            end
         end
         flash_pins_pkg::ST_SETUP: begin
            if (st_reg.cnt >= CNT_W'(SETUP_CYC - 1)) begin
               st_next.state           = flash_pins_pkg::ST_STROBE;
               st_next.cnt             = '0;
               st_next.pins.chip_act_n = 1'b0;
               if (st_reg.cur.write) begin
                  // Low byte carries the command; upper lines held for word data
                  st_next.pins.data_oe     = 1'b1;
                  st_next.pins.top_oe      = 1'b1;
                  st_next.pins.wr_strobe_n = 1'b0;
               end else begin
                  st_next.pins.out_drv_n = 1'b0;
               end
               if (!word_mode) begin
                  st_next.pins.top_out = st_reg.cur.addr[0];
                  st_next.pins.top_oe  = 1'b1;
               end
            end else begin
               st_next.cnt = st_reg.cnt + 1'b1;
            end
         end
         flash_pins_pkg::ST_STROBE: begin
            // Strobe wider than glitch filter
            if (st_reg.cnt >= CNT_W'(STROBE_CYC - 1)) begin
               st_next.state = flash_pins_pkg::ST_HOLD;
               st_next.cnt   = '0;
               if (!st_reg.cur.write) begin
                  st_next.rsp_valid = 1'b1;
                  st_next.rsp_data  = word_mode ? {in_sync[`DATA_W-1], in_sync[`DATA_W-2:0]}
                                                : {8'h00, in_sync[7:0]};
               end
               st_next.pins.wr_strobe_n = 1'b1;
               st_next.pins.out_drv_n   = 1'b1;
               st_next.pins.chip_act_n  = 1'b1;
            end else begin
               st_next.cnt = st_reg.cnt + 1'b1;
            end
         end
         flash_pins_pkg::ST_HOLD: begin
            // Data held one cycle past the rising strobe edge
            st_next.pins.data_oe = 1'b0;
            st_next.pins.top_oe  = ~word_mode;
            st_next.state        = flash_pins_pkg::ST_IDLE;
            st_next.req_ready    = 1'b1;
         end
      endcase
   end

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         st_reg                        <= '0;
         st_reg.state                  <= flash_pins_pkg::ST_RESET_LOW;
         st_reg.pins.chip_act_n        <= 1'b1;
         st_reg.pins.out_drv_n         <= 1'b1;
         st_reg.pins.wr_strobe_n       <= 1'b1;
      end else if (ce) begin
         st_reg <= st_next;
      end
   end

   assign req_ready  = st_reg.req_ready;
   assign rsp_valid  = st_reg.rsp_valid;
   assign rsp_data   = st_reg.rsp_data;
   assign ready_seen = st_reg.ready_seen;
   assign pins       = st_reg.pins;
endmodule : flash_pin_host
`default_nettype wire

// ===== tb/flash_pins_asserts.sv
// Purpose: Port assertions for the flash pin controller
// Assumes: ce held high by the bench
// Notes:   Bound into every flash_pin_host instance
`default_nettype none
`include "flash_pins_defines.svh"
module flash_pins_asserts #(
   parameter int STROBE_CYC = 4,
   parameter int SETUP_CYC  = 1
) (
   input wire logic                       mclk,
   input wire logic                       nrst,
   input wire logic                       ce,
   input wire logic                       word_mode,
   input wire logic                       req_valid,
   input wire flash_pins_pkg::bus_req_t   req,
   input wire logic                       reset_req,
   input wire logic [`DATA_W-2:0]         data_in,
   input wire logic                       top_in,
   input wire logic                       ready_busy_od,
   input wire logic                       req_ready,
   input wire logic                       rsp_valid,
   input wire logic [`DATA_W-1:0]         rsp_data,
   input wire logic                       ready_seen,
   input wire flash_pins_pkg::pin_drive_t pins
);
   localparam int LEAD   = 1 + SETUP_CYC;
   localparam int STB_M1 = STROBE_CYC - 1;
   logic [7:0] low_cnt_reg;
   logic [7:0] low_cnt_next;
   wire        take = req_valid && req_ready && !reset_req;
   default clocking @(posedge mclk); endclocking
   default disable iff (!nrst);
   // Length of the reset pulse on the pin
   always_comb low_cnt_next = pins.reset_unprotect_n ? 8'h00 : low_cnt_reg + {7'h00, low_cnt_reg != 8'hff};
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) low_cnt_reg <= 8'h00;
      else low_cnt_reg <= low_cnt_next;
   end
   sequence strobe_span; 1'b1 ##STB_M1 1'b1; endsequence
   sequence cycle_start; ##LEAD $fell(pins.chip_act_n); endsequence
   wr_oe_high_a: assert property (!pins.wr_strobe_n |-> pins.out_drv_n)
      else $error("output drive low in write");
   rd_bus_free_a: assert property (!pins.out_drv_n && pins.word_mode |-> !pins.data_oe && !pins.top_oe)
      else $error("host drives data in read");
   wr_data_on_a: assert property (!pins.wr_strobe_n |-> pins.data_oe)
      else $error("write without data");
   strobe_len_a: assert property ($fell(pins.chip_act_n) |->
      ((!pins.chip_act_n) throughout strobe_span) ##1 pins.chip_act_n)
      else $error("strobe length wrong");
   addr_hold_a: assert property (!pins.chip_act_n && $past(!pins.chip_act_n) |-> $stable(pins.addr_lines))
      else $error("address moved in cycle");
   start_lead_a: assert property (take |-> cycle_start)
      else $error("cycle start late");
   rd_done_a: assert property (rsp_valid |-> $rose(pins.chip_act_n) && pins.wr_strobe_n)
      else $error("answer off strobe end");
   rst_hold_a: assert property ($rose(pins.reset_unprotect_n) |-> low_cnt_reg >= `RESET_LOW_CYC)
      else $error("reset pulse short");
   busy_gate_a: assert property ($fell(pins.chip_act_n) |-> $past(ready_busy_od, 2) && ready_busy_od)
      else $error("cycle while busy");
endmodule : flash_pins_asserts
bind flash_pin_host flash_pins_asserts #(.STROBE_CYC(STROBE_CYC), .SETUP_CYC(SETUP_CYC)) u_chk (.*);
`default_nettype wire

// ===== tb/flash_dev_model.sv
// Purpose: Behavioural flash device on the host pins
// Assumes: Elevated levels arrive as digital qualifiers
// Notes:   Undriven lines toggle every mclk
`default_nettype none
module flash_dev_model #(
   parameter logic [15:0] MFR_CODE = 16'h1357, // Arbitrary
   parameter logic [15:0] DEV_CODE = 16'h2468, // Arbitrary
   parameter int          RDY_NS   = 200
) (
   input  wire logic                       mclk,
   input  wire flash_pins_pkg::pin_drive_t pins,
   output logic [14:0]                     data_in,
   output logic                            top_in,
   output logic                            ready_busy_od
);
   logic [15:0] word;
   logic [19:0] lat_addr;
   logic [7:0]  lat_cmd;
   logic        flt;
   logic        busy;
   wire         rd  = !pins.chip_act_n && !pins.out_drv_n && pins.wr_strobe_n;
   wire         sel = !pins.chip_act_n && !pins.wr_strobe_n;
   initial flt = 1'b0;
   always @(posedge mclk) flt <= !flt;
   always_comb word = pins.addr_elevated ? (pins.addr_lines[0] ? DEV_CODE : MFR_CODE)
                                         : pins.addr_lines[15:0] ^ 16'h5a5a;
   always_comb begin
      {top_in, data_in} = {16{flt}};
      if (rd && pins.word_mode) {top_in, data_in} = word;
      else if (rd) data_in[7:0] = pins.top_out ? word[15:8] : word[7:0];
   end
   always @(posedge sel) lat_addr = pins.addr_lines;
   always @(negedge sel) lat_cmd = pins.data_out[7:0];
   always begin
      busy = 1'b1;
      wait (pins.reset_unprotect_n === 1'b1);
      #(RDY_NS);
      if (pins.reset_unprotect_n) busy = 1'b0;
      wait (pins.reset_unprotect_n === 1'b0);
   end
   assign ready_busy_od = !busy;
endmodule : flash_dev_model
`default_nettype wire

// ===== tb/tb.sv
// Purpose: Random and corner transfers through the flash pin controller
// Assumes: ce tied high
// Notes:   Device answers from a fixed address pattern
`default_nettype none
`include "flash_pins_defines.svh"
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [15:0] MFR = 16'h1357; // Arbitrary
   localparam logic [15:0] DEV = 16'h2468; // Arbitrary
   logic mclk, nrst, word_mode, req_valid, reset_req, req_ready, rsp_valid, ready_seen, top_in, ready_busy_od;
   logic [`DATA_W-2:0]         data_in;
   logic [`DATA_W-1:0]         rsp_data;
   flash_pins_pkg::bus_req_t   req, r;
   flash_pins_pkg::pin_drive_t pins;
   int failures, comparisons, seed, n;
   flash_pin_host uut (.mclk(mclk), .nrst(nrst), .ce(1'b1), .word_mode(word_mode), .req_valid(req_valid),
      .req(req), .reset_req(reset_req), .data_in(data_in), .top_in(top_in), .ready_busy_od(ready_busy_od),
      .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_data(rsp_data), .ready_seen(ready_seen), .pins(pins));
   flash_dev_model #(.MFR_CODE(MFR), .DEV_CODE(DEV)) dev (.mclk(mclk), .pins(pins), .data_in(data_in),
      .top_in(top_in), .ready_busy_od(ready_busy_od));
   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end
   task automatic check(input logic [19:0] seen, input logic [19:0] want);
      comparisons++;
      if (seen !== want) begin
         failures++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, want);
      end
   endtask : check
   task automatic close_out;
      $display("comparisons=%0d failures=%0d", comparisons, failures);
      if (failures == 0 && comparisons > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : close_out
   function automatic logic [15:0] expect_rd(input flash_pins_pkg::bus_req_t q, input logic wm);
      logic [19:0] wa;
      logic [15:0] w;
      wa = wm ? q.addr : q.addr >> 1;
      w = q.id_mode ? (wa[0] ? DEV : MFR) : wa[15:0] ^ 16'h5a5a;
      return wm ? w : {8'h00, q.addr[0] ? w[15:8] : w[7:0]};
   endfunction : expect_rd
   task automatic xfer(input flash_pins_pkg::bus_req_t q, input logic wm);
      int k;
      @(posedge mclk);
      word_mode <= wm;
      req <= q;
      req_valid <= 1'b1;
      k = 0;
      do begin @(negedge mclk); k++; end while (req_ready !== 1'b1 && k < 2000);
      @(posedge mclk);
      req_valid <= 1'b0;
      k = 0;
      do begin @(negedge mclk); k++; end while ((q.write ? req_ready : rsp_valid) !== 1'b1 && k < 40);
      if (q.write) begin
         check(dev.lat_addr, wm ? q.addr : q.addr >> 1);
         check(20'(dev.lat_cmd), 20'(q.wdata[7:0]));
         check(20'(pins.elevated_id_level), 20'(q.unprotect));
         check(20'(ready_seen), 20'h1);
      end else check(20'(rsp_data), 20'(expect_rd(q, wm)));
   endtask : xfer
   task automatic hw_reset;
      int k;
      @(posedge mclk);
      reset_req <= 1'b1;
      k = 0;
      do begin @(negedge mclk); k++; end while (pins.reset_unprotect_n !== 1'b0 && k < 50);
      @(posedge mclk);
      reset_req <= 1'b0;
      k = 0;
      while (pins.reset_unprotect_n === 1'b0 && k < 1000) begin @(negedge mclk); k++; end
      check(20'(k >= `RESET_LOW_CYC), 20'h1);
      check(20'(ready_busy_od), 20'h0);
   endtask : hw_reset
   initial begin
      #100000;
      failures++;
      close_out;
   end
   initial begin
      seed = 32'h87c6;
      failures = 0;
      comparisons = 0;
      nrst = 1'b0;
      word_mode = 1'b1;
      req_valid = 1'b0;
      reset_req = 1'b0;
      req = '0;
      repeat (6) @(posedge mclk);
      nrst <= 1'b1;
      for (n = 0; n < 60; n++) begin
         r.write = 1'($random(seed));
         r.id_mode = (($random(seed) & 3) == 0);
         r.unprotect = 1'($random(seed));
         r.addr = 20'($random(seed));
         r.wdata = 16'($random(seed));
         // Address extremes in both widths first
         if (n < 4) r.addr = n[0] ? 20'hf_ffff : 20'h0_0000;
         if (n == 30) hw_reset();
         xfer(r, n < 4 ? n[1] : 1'($random(seed)));
      end
      close_out;
   end
endmodule : tb
`default_nettype wire
